/* src/spsf_map.svh */
// register map, field positions, reset values and rate divisors of the spi flag and buffer block
// assumes inclusion by bare name from the package and the testbench
`ifndef SPSF_MAP_SVH
`define SPSF_MAP_SVH

// register indices; byte address is four times the index
`define SPSF_IDX_CTRL      8'h10
`define SPSF_IDX_STAT      8'h11
`define SPSF_IDX_DATA      8'h12
`define SPSF_ADDR_W        8

// control register fields
`define SPSF_CTRL_RXIE     7
`define SPSF_CTRL_MASTER   5
`define SPSF_CTRL_CPOL     4
`define SPSF_CTRL_ENABLE   1
`define SPSF_CTRL_TXIE     0
`define SPSF_CTRL_RESET    8'h20

// status and control register fields
`define SPSF_STAT_RXF      7
`define SPSF_STAT_ERROR_IRQ_ENABLE    6
`define SPSF_STAT_OVR      5
`define SPSF_STAT_MODE_FAULT_FLAG     4
`define SPSF_STAT_TXE      3
`define SPSF_STAT_MFEN     2
`define SPSF_STAT_RATE_HI  1
`define SPSF_STAT_RATE_LO  0

// master rate divisors for codes 00..11
`define SPSF_DIV_00        8'h02
`define SPSF_DIV_01        8'h08
`define SPSF_DIV_10        8'h20
`define SPSF_DIV_11        8'h80

// bits per transfer
`define SPSF_BITS          4'h8

// axi response codes
`define SPSF_RESP_OKAY     2'h0
`define SPSF_RESP_SLVERR   2'h2

`endif

/* src/spsf_pkg.sv */
// types shared by the spi flag and buffer block
// assumes the map header sits beside it
package spsf_pkg;
  `include "spsf_map.svh"

  // transfer engine state
  typedef enum logic [0:0] {
    SPSF_IDLE = 1'b0,
    SPSF_BUSY = 1'b1
  } spsf_xfer_t;

  typedef logic [1:0] spsf_rate_t;
  typedef logic [7:0] spsf_byte_t;
endpackage : spsf_pkg

/* src/spsf_rate_div.sv */
// master serial clock rate divider: one tick every divisor bus cycles
// assumes the caller toggles its serial clock once per tick
`timescale 1ns/10ps
module spsf_rate_div
  import spsf_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              run,
  input  wire spsf_pkg::spsf_rate_t rate_sel,
  output logic                   tick
);
  logic [7:0] div_val;
  logic [7:0] cnt_reg;

  // divisor table; half period is one divisor, so sck is clock over twice that
  always_comb begin
    case (rate_sel)
      2'b00:   div_val = `SPSF_DIV_00;
      2'b01:   div_val = `SPSF_DIV_01;
      2'b10:   div_val = `SPSF_DIV_10;
      default: div_val = `SPSF_DIV_11;
    endcase
  end

  assign tick = run && (cnt_reg == div_val - 8'h01);

  // counter restarts whenever the engine is not running
  always_ff @(posedge aclk) begin
    if (!aresetn || !run || tick) begin
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end
endmodule : spsf_rate_div

/* src/spsf_top.sv */
// spi status flags, data buffers, minimal shift engine and axi4-lite register slave
// assumes serial pins are already synchronous to aclk; pad logic resolves the enables
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/10ps
// Function
// - receive-full sets when a finished byte lands in the receive buffer; interrupt if enabled.
// - any data register read, or reset, clears receive-full.
// - error interrupt enable gates overrun and mode-fault interrupts; reset clears it.
// - overrun sets when a new byte arrives before the previous one was read.
// - on overrun the held receive byte stays and the new byte is dropped.
// - overrun clears after status read seeing it, then data read; reset clears.
// - slave with detection on: select rising mid-transfer sets mode-fault.
// - master with detection on: select low at any time sets mode-fault.
// - mode-fault clears after status read seeing it, then data write; reset clears.
// - transmit-empty sets on each buffer-to-shifter load; interrupt if enabled; reset sets it.
// - idle engine loads a written byte and transmit-empty returns within two cycles.
// - an active slave defers the shifter load until its transfer ends.
// - detection enable only permits setting; clearing it keeps a set mode-fault.
// - master without detection ignores select, pin free for general use.
// - slave always uses select; detection off only stops mode-fault setting.
// - master rate field picks divisor 2, 8, 32, 128; ignored as slave; resets 00.
// - master serial clock equals base clock over twice the divisor.
// - data writes fill transmit buffer, reads return receive buffer; separate, undefined at reset.
// - receive and transmit interrupt enables live in control; reset clears both.
module spsf_top
  import spsf_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        sck_i,
  output logic             sck_o,
  output logic             sck_oe,
  input  wire logic        mosi_i,
  output logic             mosi_o,
  output logic             mosi_oe,
  input  wire logic        miso_i,
  output logic             miso_o,
  output logic             miso_oe,
  input  wire logic        ss_n_i,
  output logic             ss_gpio_free,
  output logic             irq
);
  // write channel holding
  logic        aw_full_reg;
  logic [7:0]  aw_idx_reg;
  logic        aw_ok_reg;
  logic        w_full_reg;
  logic [7:0]  w_data_reg;
  logic        w_lane_reg;
  logic        wr_fire;
  // register state
  logic [7:0]  ctrl_reg;
  logic        err_ie_reg;
  logic        mfen_reg;
  spsf_rate_t  rate_reg;
  spsf_byte_t  tx_buf_reg;
  spsf_byte_t  rx_buf_reg;
  logic        rx_full_reg;
  logic        ovr_reg;
  logic        mode_fault_flag_reg;
  logic        tx_empty_reg;
  logic        ovr_arm_reg;
  logic        mode_fault_flag_arm_reg;
  // engine state
  spsf_xfer_t  xfer_reg;
  spsf_byte_t  shift_reg;
  logic [3:0]  bit_cnt_reg;
  logic        rx_bit_reg;
  logic        sck_int_reg;
  logic        sck_prev_reg;
  logic        ss_prev_reg;
  // decoded strobes
  logic        is_master;
  logic        enabled;
  logic        rd_fire;
  logic [7:0]  ar_idx;
  logic        data_rd;
  logic        stat_rd;
  logic        data_wr;
  logic        tick;
  logic        lead_edge;
  logic        trail_edge;
  logic        load_go;
  logic        xfer_done;
  logic        mode_fault_flag_set;
  logic [7:0]  stat_val;

  assign is_master = ctrl_reg[`SPSF_CTRL_MASTER];
  assign enabled   = ctrl_reg[`SPSF_CTRL_ENABLE];

  // axi handshakes; one write and one read outstanding at most
  assign s_axi_awready = !aw_full_reg;
  assign s_axi_wready  = !w_full_reg;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire       = aw_full_reg && w_full_reg && !s_axi_bvalid;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;
  assign ar_idx        = s_axi_araddr[`SPSF_ADDR_W+1:2];
  assign data_rd       = rd_fire && (s_axi_araddr[1:0] == 2'b00) && (ar_idx == `SPSF_IDX_DATA);
  assign stat_rd       = rd_fire && (s_axi_araddr[1:0] == 2'b00) && (ar_idx == `SPSF_IDX_STAT);
  assign data_wr       = wr_fire && aw_ok_reg && w_lane_reg && (aw_idx_reg == `SPSF_IDX_DATA);

  // address and data may arrive in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      aw_idx_reg  <= 8'h00;
      aw_ok_reg   <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full_reg <= 1'b1;
      aw_idx_reg  <= s_axi_awaddr[`SPSF_ADDR_W+1:2];
      aw_ok_reg   <= (s_axi_awaddr[31:`SPSF_ADDR_W+2] == '0) && (s_axi_awaddr[1:0] == 2'b00);
    end else if (wr_fire) begin
      aw_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_reg <= 1'b0;
      w_data_reg <= 8'h00;
      w_lane_reg <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full_reg <= 1'b1;
      w_data_reg <= s_axi_wdata[7:0];
      w_lane_reg <= s_axi_wstrb[0]; // only byte lane 0 carries register bits
    end else if (wr_fire) begin
      w_full_reg <= 1'b0;
    end
  end

  // write response; unmapped index answers slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SPSF_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_ok_reg && (aw_idx_reg == `SPSF_IDX_CTRL || aw_idx_reg == `SPSF_IDX_STAT
                       || aw_idx_reg == `SPSF_IDX_DATA)) ? `SPSF_RESP_OKAY : `SPSF_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // control and writable status fields
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg   <= `SPSF_CTRL_RESET;
      err_ie_reg <= 1'b0;
      mfen_reg   <= 1'b0;
      rate_reg   <= 2'b00;
    end else if (wr_fire && aw_ok_reg && w_lane_reg) begin
      if (aw_idx_reg == `SPSF_IDX_CTRL) begin
        ctrl_reg <= w_data_reg;
      end else if (aw_idx_reg == `SPSF_IDX_STAT) begin
        err_ie_reg <= w_data_reg[`SPSF_STAT_ERROR_IRQ_ENABLE];
        mfen_reg   <= w_data_reg[`SPSF_STAT_MFEN];
        rate_reg   <= w_data_reg[`SPSF_STAT_RATE_HI:`SPSF_STAT_RATE_LO];
      end
    end
  end

  assign stat_val = {rx_full_reg, err_ie_reg, ovr_reg, mode_fault_flag_reg, tx_empty_reg, mfen_reg, rate_reg};

  // read data registered one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `SPSF_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `SPSF_RESP_OKAY;
      if (s_axi_araddr[1:0] != 2'b00 || s_axi_araddr[31:`SPSF_ADDR_W+2] != '0) begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `SPSF_RESP_SLVERR;
      end else if (ar_idx == `SPSF_IDX_CTRL) begin
        s_axi_rdata <= {24'h000000, ctrl_reg};
      end else if (ar_idx == `SPSF_IDX_STAT) begin
        s_axi_rdata <= {24'h000000, stat_val};
      end else if (ar_idx == `SPSF_IDX_DATA) begin
        s_axi_rdata <= {24'h000000, rx_buf_reg};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `SPSF_RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // transmit buffer has no reset: contents undefined until first write
  always_ff @(posedge aclk) begin
    if (data_wr) begin
      tx_buf_reg <= w_data_reg;
    end
  end

  // load when buffer full and engine idle; a busy slave waits for its end
  assign load_go = enabled && !tx_empty_reg && (xfer_reg == SPSF_IDLE);

  // transmit-empty: load sets it, data write drops it, set wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_empty_reg <= 1'b1;
    end else if (load_go) begin
      tx_empty_reg <= 1'b1;
    end else if (data_wr) begin
      tx_empty_reg <= 1'b0;
    end
  end

  spsf_rate_div u_rate_div (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .run      (is_master && (xfer_reg == SPSF_BUSY)),
    .rate_sel (rate_reg),
    .tick     (tick)
  );

  // edges: master from the divider, slave from sck while selected
  always_comb begin
    lead_edge  = 1'b0;
    trail_edge = 1'b0;
    if (is_master) begin
      lead_edge  = tick && (sck_int_reg == ctrl_reg[`SPSF_CTRL_CPOL]);
      trail_edge = tick && (sck_int_reg != ctrl_reg[`SPSF_CTRL_CPOL]);
    end else if (enabled && !ss_n_i && (sck_i != sck_prev_reg)) begin
      lead_edge  = (sck_i != ctrl_reg[`SPSF_CTRL_CPOL]);
      trail_edge = (sck_i == ctrl_reg[`SPSF_CTRL_CPOL]);
    end
  end

  assign xfer_done = trail_edge && (xfer_reg == SPSF_BUSY) && (bit_cnt_reg == `SPSF_BITS);

  // engine state; a master fault aborts so two masters stop fighting
  always_ff @(posedge aclk) begin
    if (!aresetn || !enabled) begin
      xfer_reg <= SPSF_IDLE;
    end else begin
      case (xfer_reg)
        SPSF_IDLE: begin
          if ((is_master && load_go) || (!is_master && lead_edge)) begin
            xfer_reg <= SPSF_BUSY;
          end
        end
        SPSF_BUSY: begin
          if (xfer_done || (is_master && mode_fault_flag_set)) begin
            xfer_reg <= SPSF_IDLE;
          end
        end
        default: xfer_reg <= SPSF_IDLE;
      endcase
    end
  end

  // shifter: sample on leading edge, shift on trailing edge, msb first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shift_reg   <= 8'h00;
      bit_cnt_reg <= 4'h0;
      rx_bit_reg  <= 1'b0;
    end else if (load_go) begin
      shift_reg   <= tx_buf_reg;
      bit_cnt_reg <= 4'h0;
    end else if (xfer_done || xfer_reg == SPSF_IDLE) begin
      shift_reg   <= xfer_done ? {shift_reg[6:0], rx_bit_reg} : shift_reg;
      bit_cnt_reg <= (lead_edge && !is_master) ? 4'h1 : 4'h0;
      rx_bit_reg  <= (lead_edge && !is_master) ? mosi_i : rx_bit_reg;
    end else if (lead_edge) begin
      rx_bit_reg  <= is_master ? miso_i : mosi_i;
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end else if (trail_edge) begin
      shift_reg <= {shift_reg[6:0], rx_bit_reg};
    end
  end

  // serial clock and pin history
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sck_int_reg  <= 1'b0;
      sck_prev_reg <= 1'b0;
      ss_prev_reg  <= 1'b1;
    end else begin
      sck_int_reg  <= (xfer_reg == SPSF_IDLE) ? ctrl_reg[`SPSF_CTRL_CPOL] :
                      (tick ? !sck_int_reg : sck_int_reg);
      sck_prev_reg <= sck_i;
      ss_prev_reg  <= ss_n_i;
    end
  end

  // receive buffer keeps old byte on overrun; no reset, undefined until first byte
  always_ff @(posedge aclk) begin
    if (xfer_done && !rx_full_reg) begin
      rx_buf_reg <= {shift_reg[6:0], rx_bit_reg};
    end
  end

  // receive-full: completion sets, any data read clears, set wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_full_reg <= 1'b0;
    end else if (xfer_done) begin
      rx_full_reg <= 1'b1;
    end else if (data_rd) begin
      rx_full_reg <= 1'b0;
    end
  end

  // overrun arms on a status read that sees it, clears on a later data read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovr_reg     <= 1'b0;
      ovr_arm_reg <= 1'b0;
    end else if (xfer_done && rx_full_reg) begin
      ovr_reg     <= 1'b1;
      ovr_arm_reg <= 1'b0;
    end else if (stat_rd) begin
      ovr_arm_reg <= ovr_reg;
    end else if (data_rd && ovr_arm_reg) begin
      ovr_reg     <= 1'b0;
      ovr_arm_reg <= 1'b0;
    end
  end

  // fault sources; master without detection ignores select entirely
  assign mode_fault_flag_set = enabled && mfen_reg &&
                    ((is_master && !ss_n_i) ||
                     (!is_master && (xfer_reg == SPSF_BUSY) && ss_n_i && !ss_prev_reg));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_fault_flag_reg     <= 1'b0;
      mode_fault_flag_arm_reg <= 1'b0;
    end else if (mode_fault_flag_set) begin
      mode_fault_flag_reg     <= 1'b1;
      mode_fault_flag_arm_reg <= 1'b0;
    end else if (stat_rd) begin
      mode_fault_flag_arm_reg <= mode_fault_flag_reg;
    end else if (data_wr && mode_fault_flag_arm_reg) begin
      mode_fault_flag_reg     <= 1'b0;
      mode_fault_flag_arm_reg <= 1'b0;
    end
  end

  // pins: master drives sck and mosi, selected slave drives miso
  assign sck_o        = sck_int_reg;
  assign sck_oe       = enabled && is_master;
  assign mosi_o       = shift_reg[7];
  assign mosi_oe      = enabled && is_master;
  assign miso_o       = shift_reg[7];
  assign miso_oe      = enabled && !is_master && !ss_n_i;
  assign ss_gpio_free = !enabled || (is_master && !mfen_reg);

  // one level request while any enabled flag stands
  assign irq = (rx_full_reg && ctrl_reg[`SPSF_CTRL_RXIE]) ||
               (tx_empty_reg && ctrl_reg[`SPSF_CTRL_TXIE]) ||
               (err_ie_reg && (ovr_reg || mode_fault_flag_reg));

  // named steps for flag clearing
  sequence s_ovr_seen;
    stat_rd && ovr_reg && !(xfer_done && rx_full_reg);
  endsequence

  sequence s_data_read_no_new;
    data_rd && !xfer_done;
  endsequence

  sequence s_armed_data_read;
    data_rd && ovr_arm_reg && !xfer_done;
  endsequence

  a_rxf_set: assert property (@(posedge aclk) disable iff (!aresetn)
    xfer_done |=> rx_full_reg) else $error("receive-full not set after byte");
  a_rxf_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    s_data_read_no_new |=> !rx_full_reg) else $error("data read left receive-full");
  a_ovr_keep_buf: assert property (@(posedge aclk) disable iff (!aresetn)
    (xfer_done && rx_full_reg) |=> (ovr_reg && rx_buf_reg == $past(rx_buf_reg))) else $error("overrun mishandled");
  a_ovr_arm_seen: assert property (@(posedge aclk) disable iff (!aresetn)
    s_ovr_seen |=> ovr_arm_reg) else $error("overrun status read did not arm clear");
  a_ovr_two_step: assert property (@(posedge aclk) disable iff (!aresetn)
    s_armed_data_read |=> !ovr_reg) else $error("overrun not cleared");
  a_ovr_needs_arm: assert property (@(posedge aclk) disable iff (!aresetn)
    (ovr_reg && !ovr_arm_reg && !stat_rd) |=> ovr_reg) else $error("overrun cleared without status read");
  a_mode_fault_flag_master: assert property (@(posedge aclk) disable iff (!aresetn)
    (enabled && is_master && mfen_reg && !ss_n_i) |=> mode_fault_flag_reg) else $error("master fault missed");
  a_mode_fault_flag_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode_fault_flag_reg && !(data_wr && mode_fault_flag_arm_reg)) |=> mode_fault_flag_reg) else $error("mode-fault lost");
  a_mode_fault_flag_none: assert property (@(posedge aclk) disable iff (!aresetn)
    (!mfen_reg && !mode_fault_flag_reg) |=> !mode_fault_flag_reg) else $error("mode-fault with detection off");
  a_txe_return: assert property (@(posedge aclk) disable iff (!aresetn)
    (data_wr && enabled && xfer_reg == SPSF_IDLE && tx_empty_reg) |=> !tx_empty_reg ##1 tx_empty_reg)
    else $error("transmit-empty not back in two cycles");
  a_slave_defer: assert property (@(posedge aclk) disable iff (!aresetn)
    (!is_master && xfer_reg == SPSF_BUSY) |-> !load_go) else $error("slave loaded mid-transfer");
  a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
    (err_ie_reg && ovr_reg) |-> irq) else $error("error interrupt missing");
endmodule : spsf_top

/* testbench/spsf_peer_slave.sv */
// peer spi slave on the far side of the serial link, mode 0 timing
// assumes the master idles its clock low and selects this peer through sel_n
`timescale 1ns/10ps
module spsf_peer_slave (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       sel_n,
  input  wire logic [7:0] tx_byte,
  output logic            miso,
  output logic [7:0]      rx_byte
);
  logic [7:0] sh;
  logic       last = 1'b0;
  // deselected line shows the inverse of the last bit, never a stale copy
  assign miso = sel_n ? ~last : sh[7];
  // byte latched at select so it is ready before the first sample edge
  always @(negedge sel_n) sh = tx_byte;
  // sample on the leading edge, msb first
  always @(posedge sck) if (!sel_n) rx_byte = {rx_byte[6:0], mosi};
  // shift on the trailing edge
  always @(negedge sck) begin
    if (!sel_n) begin
      last = sh[7];
      sh   = {sh[6:0], 1'b0};
    end
  end
endmodule : spsf_peer_slave

/* testbench/spsf_top_test.sv */
// self-checking bench for the spi flag and buffer block, acting as axi4-lite master
// assumes the design sources and the peer slave model are compiled first
`timescale 1ns/10ps
`include "spsf_map.svh"
module spsf_top_test;
  import spsf_pkg::*;
  logic        aclk = 0, aresetn = 0, sck_q = 0;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
  logic        awvalid = 0, wvalid = 0, bready = 1, arvalid = 0, rready = 1;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic        sck, mosi, miso, ss_n = 1, sel_n = 1, free, irq;
  logic        sck_s = 0, sck_oe, mosi_oe, miso_oe;
  logic [7:0]  peer_tx = 0, peer_rx, b0;
  logic [33:0] expq[$];
  int          miscompares = 0, num_checks = 0, tgl = 0, gap = 0, want = 2;

  always #20 aclk = ~aclk;

  spsf_top u_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sck_i(sck_s), .sck_o(sck), .sck_oe(sck_oe), .mosi_i(1'b0), .mosi_o(mosi), .mosi_oe(mosi_oe),
    .miso_i(miso), .miso_o(), .miso_oe(miso_oe), .ss_n_i(ss_n), .ss_gpio_free(free), .irq(irq));

  spsf_peer_slave u_peer (.sck(sck), .mosi(mosi), .sel_n(sel_n), .tx_byte(peer_tx),
    .miso(miso), .rx_byte(peer_rx));

  task automatic stop_test();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [33:0] seen, input logic [33:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // every polling wait goes through here so a hang ends in the report
  task automatic tick(inout int n);
    @(posedge aclk);
    n++;
    if (n > 3000) begin
      miscompares++;
      stop_test();
    end
  endtask : tick

  // bready stays high, so only the address and data channels are released
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    awaddr  <= {22'h0, idx, 2'h0};
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      tick(n);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    chk("bresp", {32'h0, bresp}, {32'h0, `SPSF_RESP_OKAY});
  endtask : wr

  // expected response and data are queued for the read monitor
  task automatic rd(input logic [7:0] idx, input logic [33:0] exp);
    int n;
    n = 0;
    expq.push_back(exp);
    araddr  <= {22'h0, idx, 2'h0};
    arvalid <= 1'b1;
    do begin
      tick(n);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
  endtask : rd

  // one byte frame with the peer; status is sampled while the shifter runs
  task automatic frame(input logic [7:0] p, input logic [7:0] d, input logic [7:0] st);
    int n, base;
    n = 0;
    peer_tx = p;
    sel_n = 0;
    base = tgl;
    wr(`SPSF_IDX_DATA, d);
    rd(`SPSF_IDX_STAT, {26'h0, st});
    while (tgl < base + 16) tick(n);
    repeat (2) @(posedge aclk);
    sel_n = 1;
    @(posedge aclk);
  endtask : frame

  // read monitor takes the oldest note whenever a read answer is accepted
  always @(posedge aclk) begin
    if (rvalid && rready) begin
      if (expq.size() == 0) chk("stray read", 34'h0, 34'h1);
      else chk("read", {rresp, rdata}, expq.pop_front());
    end
  end

  // serial clock spacing; the first toggle of each frame waits on the load
  always @(posedge aclk) begin
    sck_q <= sck;
    gap   <= gap + 1;
    if (aresetn && sck !== sck_q) begin
      if (tgl % 16 != 0) chk("half period", 34'(gap), 34'(want));
      tgl <= tgl + 1;
      gap <= 1;
    end
  end

  initial begin
    void'($urandom(32'hE9BB));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`SPSF_IDX_CTRL, {26'h0, `SPSF_CTRL_RESET});
    rd(`SPSF_IDX_STAT, 34'h08);
    rd(8'h13, {`SPSF_RESP_SLVERR, 32'h0});
    wr(`SPSF_IDX_CTRL, 8'h22);
    chk("select free", 34'(free), 34'h1);
    chk("pin enables", 34'({sck_oe, mosi_oe, miso_oe}), 34'h6);
    for (int r = 0; r < 4; r++) begin
      want = 2 << (2 * r);
      wr(`SPSF_IDX_STAT, 8'(r));
      b0 = 8'($urandom);
      frame(8'($urandom), b0, 8'h08 | 8'(r));
      rd(`SPSF_IDX_STAT, {26'h0, 8'h88 | 8'(r)});
      rd(`SPSF_IDX_DATA, {26'h0, peer_tx});
      rd(`SPSF_IDX_STAT, {26'h0, 8'h08 | 8'(r)});
      chk("peer rx", 34'(peer_rx), 34'(b0));
    end
    // overrun: second byte completes while the first is still unread
    want = 2;
    wr(`SPSF_IDX_STAT, 8'h00);
    b0 = 8'($urandom);
    frame(b0, 8'($urandom), 8'h08);
    frame(8'($urandom), 8'($urandom), 8'h88);
    rd(`SPSF_IDX_STAT, 34'hA8);
    rd(`SPSF_IDX_DATA, {26'h0, b0});
    rd(`SPSF_IDX_STAT, 34'h08);
    // select low on a master: ignored until detection is on
    ss_n <= 1'b0;
    rd(`SPSF_IDX_STAT, 34'h08);
    wr(`SPSF_IDX_STAT, 8'h04);
    chk("select free", 34'(free), 34'h0);
    chk("irq gated", 34'(irq), 34'h0);
    wr(`SPSF_IDX_STAT, 8'h44);
    chk("irq error", 34'(irq), 34'h1);
    ss_n <= 1'b1;
    rd(`SPSF_IDX_STAT, 34'h5C);
    wr(`SPSF_IDX_STAT, 8'h40);
    rd(`SPSF_IDX_STAT, 34'h58);
    wr(`SPSF_IDX_DATA, 8'($urandom));
    chk("irq cleared", 34'(irq), 34'h0);
    // let the byte just queued finish on the deselected peer
    repeat (40) @(posedge aclk);
    // slave: select rising mid-transfer faults, the shifter load waits for the end
    wr(`SPSF_IDX_CTRL, 8'h02);
    wr(`SPSF_IDX_STAT, 8'h04);
    ss_n  <= 1'b0;
    sck_s <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("pin enables", 34'({sck_oe, mosi_oe, miso_oe}), 34'h1);
    ss_n <= 1'b1;
    @(posedge aclk);
    rd(`SPSF_IDX_STAT, 34'h9C);
    wr(`SPSF_IDX_DATA, 8'($urandom));
    rd(`SPSF_IDX_STAT, 34'h84);
    wr(`SPSF_IDX_CTRL, 8'h82);
    chk("irq receive", 34'(irq), 34'h1);
    stop_test();
  end
endmodule : spsf_top_test
